// file: hw/acqtc_top.sv
// Acquisition and frame start trigger sequencer with Avalon-MM registers
//
// Overview of operation
// - With both triggers off the block starts acquisitions and frames by itself, free running.
// - Internal frame pacing follows the period register, or the minimum period when the register is below it.
// - With the acquisition trigger off every acquisition start is made internally.
// - A trigger sourced from line one fires on a rising edge of that line.
// - Line one is the bidirectional line and is forced to input while it is a trigger source.
// - An acquisition trigger edge on line one moves waiting-acquisition to waiting-frame.
// - After the set frames-per-acquisition count the block goes back to waiting-acquisition.
// - With the frame trigger off frame starts come from the internal pacer.
// - Frame start events seen while waiting for acquisition start are dropped.
//
// Design decisions made here: the address map and the Avalon-MM register port.
`timescale 1ns/100ps
module acqtc_top
  import acqtc_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int PER_W = 24
)
(
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic [4:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  output logic      [31:0] AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  input  wire logic        LINE1_I,
  output logic             LINE1_O,
  output logic             LINE1_OE_N_O,
  output logic             FRAME_START_O,
  output logic             WAIT_ACQ_O,
  output logic             WAIT_FRM_O
);

  if (CNT_W < 1 || CNT_W > 16 || PER_W < 8 || PER_W > 24)
  begin : g_param_check
    $error("acqtc_top: CNT_W must be 1..16 and PER_W 8..24");
  end

  // The pacer's divider holds at most 128 clock cycles per time-base step
  if (ACQTC_TB_CYCLES < 1 || ACQTC_TB_CYCLES > 128)
  begin : g_time_base_check
    $error("acqtc_top: time base must be 1..128 clock cycles");
  end

  acqtc_req_type   req;
  acqtc_ctrl_type  ctrl_r;
  acqtc_ctrl_type  ctrl_nxt;
  logic [CNT_W-1:0] frm_count_r;
  logic [CNT_W-1:0] frm_count_nxt;
  logic [PER_W-1:0] period_r;
  logic [PER_W-1:0] period_nxt;
  logic [PER_W-1:0] min_per_r;
  logic [PER_W-1:0] min_per_nxt;
  logic             wait_r;
  logic             wait_nxt;
  logic [31:0]      rdata_r;
  logic [31:0]      rdata_nxt;
  logic             wr_take;

  acqtc_state_type  state_r;
  acqtc_state_type  state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             fstart_r;
  logic             fstart_nxt;
  logic             line_o_r;
  logic             line_o_nxt;
  logic             oe_n_r;
  logic             oe_n_nxt;

  logic             line_rise;
  logic             pace_tick;
  logic             pace_run;
  logic             acq_event;
  logic             frm_event;
  logic             last_frame;

  // Status word, read back by software
  function automatic logic [31:0] status_word(input acqtc_state_type st,
                                              input logic [CNT_W-1:0] cnt,
                                              input logic line);
    logic [31:0] w;
    w = 32'h00000000;
    w[ACQTC_STAT_WAIT_ACQ_BIT] = (st == ACQTC_WAIT_ACQ);
    w[ACQTC_STAT_WAIT_FRM_BIT] = (st == ACQTC_WAIT_FRM);
    w[ACQTC_STAT_LINE_BIT]     = line;
    w[ACQTC_STAT_CNT_LSB +: CNT_W] = cnt;
    return w;
  endfunction

  always_comb
  begin
    req.read      = AVS_READ_I;
    req.write     = AVS_WRITE_I;
    req.address   = AVS_ADDRESS_I;
    req.writedata = AVS_WRITEDATA_I;
  end

  // Register index: 0 control, 1 frame count, 2 period, 3 minimum period, 4 status, 7 none
  function automatic logic [2:0] reg_index(input logic [4:0] addr);
    logic [2:0] idx;
    unique case (addr)
      5'(ACQTC_CTRL_OFS):      idx = 3'h0;
      5'(ACQTC_FRM_COUNT_OFS): idx = 3'h1;
      5'(ACQTC_PERIOD_OFS):    idx = 3'h2;
      5'(ACQTC_MIN_PER_OFS):   idx = 3'h3;
      ACQTC_STAT_OFS:          idx = 3'h4;
      default:                 idx = 3'h7;
    endcase
    return idx;
  endfunction

  // Bus handshake: one wait state, then the answer edge
  // Waitrequest rests high, so the read word is always registered before it is answered
  always_comb
  begin
    wait_nxt  = !((req.read || req.write) && wait_r);
    wr_take   = req.write && !wait_r;
    rdata_nxt = rdata_r;
    if (req.read && wait_r)
    begin
      unique case (reg_index(req.address))
        3'h0:    rdata_nxt = {26'h0000000, ctrl_r};
        3'h1:    rdata_nxt = 32'(frm_count_r);
        3'h2:    rdata_nxt = 32'(period_r);
        3'h3:    rdata_nxt = 32'(min_per_r);
        3'h4:    rdata_nxt = status_word(state_r, cnt_r, LINE1_I);
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I)
    begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h00000000;
    end
    else
    begin
      wait_r  <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Register file: a write lands on the edge that answers it
  always_comb
  begin
    ctrl_nxt      = ctrl_r;
    frm_count_nxt = frm_count_r;
    period_nxt    = period_r;
    min_per_nxt   = min_per_r;
    if (wr_take)
    begin
      unique case (reg_index(req.address))
        3'h0:    ctrl_nxt      = acqtc_ctrl_type'(req.writedata[5:0]);
        3'h1:    frm_count_nxt = req.writedata[CNT_W-1:0];
        3'h2:    period_nxt    = req.writedata[PER_W-1:0];
        3'h3:    min_per_nxt   = req.writedata[PER_W-1:0];
        default: ctrl_nxt      = ctrl_r;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I)
    begin
      ctrl_r      <= acqtc_ctrl_type'(ACQTC_CTRL_RST);
      frm_count_r <= CNT_W'(ACQTC_FRM_COUNT_RST);
      period_r    <= PER_W'(ACQTC_PERIOD_RST);
      min_per_r   <= PER_W'(ACQTC_MIN_PER_RST);
    end
    else
    begin
      ctrl_r      <= ctrl_nxt;
      frm_count_r <= frm_count_nxt;
      period_r    <= period_nxt;
      min_per_r   <= min_per_nxt;
    end
  end

  // A line held high gives one event only; it must fall before it can trigger again
  acqtc_edge u_edge
  (
    .sys_clk_i (SYS_CLK_I),
    .rst_n_i   (RST_N_I),
    .level_i   (LINE1_I),
    .rise_o    (line_rise)
  );

  // Pacer restarts on each entry to waiting-frame, so the first frame waits a full period
  // pacer runs only while frames are internal
  assign pace_run = (state_r == ACQTC_WAIT_FRM) && !ctrl_r.frm_en;

  acqtc_pacer #(
    .PER_W (PER_W)
  ) u_pacer
  (
    .sys_clk_i    (SYS_CLK_I),
    .rst_n_i      (RST_N_I),
    .run_i        (pace_run),
    .period_i     (period_r),
    .min_period_i (min_per_r),
    .tick_o       (pace_tick)
  );

  always_comb
  begin
    acq_event = !ctrl_r.acq_en || (ctrl_r.acq_src_line && line_rise);
    frm_event = ctrl_r.frm_en ? (ctrl_r.frm_src_line && line_rise) : pace_tick;
    // Frame count of zero behaves as one, so an acquisition always ends
    last_frame = (cnt_r + CNT_W'(1) >= frm_count_r);
  end

  // Sequencer
  always_comb
  begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    fstart_nxt = 1'b0;
    unique case (state_r)
      ACQTC_WAIT_ACQ:
      begin
        if (acq_event)
        begin
          state_nxt = ACQTC_WAIT_FRM;
          cnt_nxt   = '0;
        end
      end
      ACQTC_WAIT_FRM:
      begin
        if (frm_event)
        begin
          fstart_nxt = 1'b1;
          cnt_nxt    = cnt_r + CNT_W'(1);
          if (last_frame)
            state_nxt = ACQTC_WAIT_ACQ;
        end
      end
      default:
      begin
        state_nxt = ACQTC_WAIT_ACQ;
        cnt_nxt   = '0;
      end
    endcase
  end

  // A trigger input overrides the output setting, so the block never triggers on its own drive
  // line forced to input as trigger source
  always_comb
  begin
    oe_n_nxt   = !(ctrl_r.line_out
                   && !(ctrl_r.acq_en && ctrl_r.acq_src_line)
                   && !(ctrl_r.frm_en && ctrl_r.frm_src_line));
    line_o_nxt = ctrl_r.line_val;
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I)
    begin
      state_r  <= ACQTC_WAIT_ACQ;
      cnt_r    <= '0;
      fstart_r <= 1'b0;
      oe_n_r   <= 1'b1;
      line_o_r <= 1'b0;
    end
    else
    begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      fstart_r <= fstart_nxt;
      oe_n_r   <= oe_n_nxt;
      line_o_r <= line_o_nxt;
    end
  end

  assign AVS_READDATA_O    = rdata_r;
  assign AVS_WAITREQUEST_O = wait_r;
  assign LINE1_O           = line_o_r;
  assign LINE1_OE_N_O      = oe_n_r;
  assign FRAME_START_O     = fstart_r;
  // One-hot codes: each flag is one state bit, straight from its flip-flop
  assign WAIT_ACQ_O        = state_r[0];
  assign WAIT_FRM_O        = state_r[1];

endmodule // acqtc_top

// file: hw/acqtc_pkg.sv
// Package with register map, field layout, reset values and timing for trigger control
package acqtc_pkg;

  // Register byte offsets
  localparam logic [3:0] ACQTC_CTRL_OFS      = 4'h0;
  localparam logic [3:0] ACQTC_FRM_COUNT_OFS = 4'h4;
  localparam logic [3:0] ACQTC_PERIOD_OFS    = 4'h8;
  localparam logic [3:0] ACQTC_MIN_PER_OFS   = 4'hC;
  localparam logic [4:0] ACQTC_STAT_OFS      = 5'h10;

  // Control register bit positions
  localparam int ACQTC_CTRL_ACQ_EN_BIT  = 0;
  localparam int ACQTC_CTRL_ACQ_SRC_BIT = 1;
  localparam int ACQTC_CTRL_FRM_EN_BIT  = 2;
  localparam int ACQTC_CTRL_FRM_SRC_BIT = 3;
  localparam int ACQTC_CTRL_LINE_OUT_BIT = 4;
  localparam int ACQTC_CTRL_LINE_VAL_BIT = 5;

  // Status register bit positions
  localparam int ACQTC_STAT_WAIT_ACQ_BIT = 0;
  localparam int ACQTC_STAT_WAIT_FRM_BIT = 1;
  localparam int ACQTC_STAT_LINE_BIT     = 2;
  localparam int ACQTC_STAT_CNT_LSB      = 8;

  // Reset values
  localparam logic [5:0]  ACQTC_CTRL_RST      = 6'h00;
  localparam logic [15:0] ACQTC_FRM_COUNT_RST = 16'h0001;
  localparam logic [23:0] ACQTC_PERIOD_RST    = 24'h000000;
  localparam logic [23:0] ACQTC_MIN_PER_RST   = 24'h002710;

  // Timing: period settings count in a 1 us time base
  localparam int ACQTC_CLK_PERIOD_NS = 10;
  localparam int ACQTC_TIME_BASE_NS  = 1000;
  localparam int ACQTC_TB_CYCLES     = ACQTC_TIME_BASE_NS / ACQTC_CLK_PERIOD_NS;

  typedef struct packed {
    logic line_val;
    logic line_out;
    logic frm_src_line;
    logic frm_en;
    logic acq_src_line;
    logic acq_en;
  } acqtc_ctrl_type;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
  } acqtc_req_type;

  typedef enum logic [1:0] {
    ACQTC_WAIT_ACQ = 2'b01,
    ACQTC_WAIT_FRM = 2'b10
  } acqtc_state_type;

endpackage

// file: hw/acqtc_edge.sv
// Rising edge detector for the general-purpose line
`timescale 1ns/100ps
module acqtc_edge
  import acqtc_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  input  wire logic level_i,
  output logic      rise_o
);
  logic prev_r;
  logic prev_nxt;

  always_comb
  begin
    prev_nxt = level_i;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      prev_r <= 1'b0;
    else
      prev_r <= prev_nxt;
  end

  assign rise_o = level_i & ~prev_r;
endmodule // acqtc_edge

// file: hw/acqtc_pacer.sv
// Internal frame pacer: microsecond divider and period counter
`timescale 1ns/100ps
module acqtc_pacer
  import acqtc_pkg::*;
#(
  parameter int PER_W = 24
)
(
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             run_i,
  input  wire logic [PER_W-1:0] period_i,
  input  wire logic [PER_W-1:0] min_period_i,
  output logic                  tick_o
);
  localparam logic [6:0] TB_LAST = 7'(ACQTC_TB_CYCLES - 1);

  logic [6:0]       div_r;
  logic [6:0]       div_nxt;
  logic [PER_W-1:0] cnt_r;
  logic [PER_W-1:0] cnt_nxt;
  logic [PER_W-1:0] target;
  logic             us_tick;

  always_comb
  begin
    target = (period_i < min_period_i) ? min_period_i : period_i;
    if (target == '0)
      target = PER_W'(1);
  end

  always_comb
  begin
    us_tick = run_i && (div_r == TB_LAST);
    div_nxt = (!run_i || us_tick) ? 7'h00 : div_r + 7'h01;
    cnt_nxt = cnt_r;
    tick_o  = 1'b0;
    if (!run_i)
      cnt_nxt = '0;
    else if (us_tick)
    begin
      if (cnt_r >= target - PER_W'(1))
      begin
        cnt_nxt = '0;
        tick_o  = 1'b1;
      end
      else
        cnt_nxt = cnt_r + PER_W'(1);
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      div_r <= 7'h00;
      cnt_r <= '0;
    end
    else
    begin
      div_r <= div_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule // acqtc_pacer

// file: sim/acqtc_asserts.sv
// Port-level checks for the trigger sequencer
`timescale 1ns/100ps
module acqtc_asserts
(
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic FRAME_START_O,
  input wire logic WAIT_ACQ_O,
  input wire logic WAIT_FRM_O
);
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  sequence s_req;
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
  endsequence
  sequence s_ans;
    !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O;
  endsequence

  a_bus_answer: assert property (s_req |=> s_ans)
    else $error("bus answer not one cycle");
  a_wait_cause: assert property ($fell(AVS_WAITREQUEST_O) |-> $past(AVS_READ_I || AVS_WRITE_I))
    else $error("answer without request");
  a_state_onehot: assert property (WAIT_ACQ_O != WAIT_FRM_O)
    else $error("state flags not exclusive");
  a_start_frm: assert property (FRAME_START_O |-> $past(WAIT_FRM_O))
    else $error("frame start outside wait frame");
  a_start_pulse: assert property (FRAME_START_O |=> !FRAME_START_O)
    else $error("frame start longer than one cycle");
  a_acq_quiet: assert property (WAIT_ACQ_O && $past(WAIT_ACQ_O) |-> !FRAME_START_O)
    else $error("frame start while waiting acquisition");
  a_acq_return: assert property ($rose(WAIT_ACQ_O) |-> FRAME_START_O)
    else $error("return to wait acquisition without frame");
  a_frm_entry: assert property ($rose(WAIT_FRM_O) |-> !FRAME_START_O)
    else $error("frame start on entry edge");
endmodule // acqtc_asserts

bind acqtc_top acqtc_asserts u_chk (.SYS_CLK_I, .RST_N_I, .AVS_READ_I, .AVS_WRITE_I,
  .AVS_WAITREQUEST_O, .FRAME_START_O, .WAIT_ACQ_O, .WAIT_FRM_O);

// file: sim/acqtc_ext_model.sv
// External sensing device that pulses line one
`timescale 1ns/100ps
module acqtc_ext_model
(
  input  wire logic clk_i,
  output logic      line_o
);
  initial line_o = 1'b0;

  // one edge each
  // Low time equals high time, so a short gap still leaves the line low between edges
  task automatic edge_once(input int gap);
    @(posedge clk_i);
    line_o <= 1'b1;
    repeat (gap) @(posedge clk_i);
    line_o <= 1'b0;
    repeat (gap) @(posedge clk_i);
  endtask
endmodule // acqtc_ext_model

// file: sim/acqtc_top_test.sv
// Self-checking bench for the trigger sequencer
`timescale 1ns/100ps
module acqtc_top_test
  import acqtc_pkg::*;
;
  typedef struct {
    logic [5:0]  ctrl;
    logic [15:0] cnt;
    logic [23:0] per;
    int          edges;
    int          wt;
    int          frames;
    logic        acq;
    logic        oen;
    logic [15:0] fcnt;
  } acqtc_row_type;

  logic        SYS_CLK_I;
  logic        RST_N_I;
  logic [4:0]  AVS_ADDRESS_I;
  logic        AVS_READ_I;
  logic        AVS_WRITE_I;
  logic [31:0] AVS_WRITEDATA_I;
  logic [31:0] AVS_READDATA_O;
  logic        AVS_WAITREQUEST_O;
  logic        LINE1_I;
  logic        LINE1_O;
  logic        LINE1_OE_N_O;
  logic        FRAME_START_O;
  logic        WAIT_ACQ_O;
  logic        WAIT_FRM_O;
  logic        ext_line;
  logic [31:0] q;
  int          err_count;
  int          samples_checked;
  int          nfr;
  int          base;

  // Rows start in wait-acquisition, except row 3, which follows a row with the acquisition trigger off
  acqtc_row_type rows [6] = '{
    '{6'h0F, 16'h0003, 24'h000001, 4, 20, 3, 1'b1, 1'b1, 16'h0003},
    '{6'h0F, 16'h0002, 24'h000001, 6, 20, 4, 1'b1, 1'b1, 16'h0002},
    '{6'h1C, 16'h0001, 24'h000001, 3, 20, 3, 1'b0, 1'b1, 16'h0000},
    '{6'h03, 16'h0003, 24'h000001, 0, 400, 3, 1'b1, 1'b1, 16'h0003},
    '{6'h03, 16'h0002, 24'h000002, 1, 500, 2, 1'b1, 1'b1, 16'h0002},
    '{6'h30, 16'h0001, 24'h000000, 0, 450, 4, 1'b0, 1'b0, 16'h0000}};

  acqtc_top uut (.SYS_CLK_I, .RST_N_I, .AVS_ADDRESS_I, .AVS_READ_I, .AVS_WRITE_I,
    .AVS_WRITEDATA_I, .AVS_READDATA_O, .AVS_WAITREQUEST_O, .LINE1_I, .LINE1_O,
    .LINE1_OE_N_O, .FRAME_START_O, .WAIT_ACQ_O, .WAIT_FRM_O);
  acqtc_ext_model ext (.clk_i(SYS_CLK_I), .line_o(ext_line));

  assign LINE1_I = LINE1_OE_N_O ? ext_line : LINE1_O;

  initial
  begin
    SYS_CLK_I = 1'b0;
    forever #5 SYS_CLK_I = ~SYS_CLK_I;
  end

  always @(posedge SYS_CLK_I)
    if (FRAME_START_O === 1'b1)
      nfr <= nfr + 1;

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task final_report();
    if (err_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge SYS_CLK_I);
    AVS_WRITE_I <= w;
    AVS_READ_I <= !w;
    AVS_ADDRESS_I <= a;
    AVS_WRITEDATA_I <= d;
    n = 0;
    do
    begin
      @(posedge SYS_CLK_I);
      n++;
    end
    while (AVS_WAITREQUEST_O !== 1'b0 && n < 50);
    if (AVS_WAITREQUEST_O !== 1'b0)
    begin
      err_count++;
      final_report();
    end
    q = AVS_READDATA_O;
    AVS_WRITE_I <= 1'b0;
    AVS_READ_I <= 1'b0;
  endtask

  initial
  begin
    RST_N_I = 1'b0;
    AVS_ADDRESS_I = 5'h00;
    AVS_READ_I = 1'b0;
    AVS_WRITE_I = 1'b0;
    AVS_WRITEDATA_I = 32'h0;
    err_count = 0;
    samples_checked = 0;
    nfr = 0;
    repeat (12) @(posedge SYS_CLK_I);
    RST_N_I <= 1'b1;
    repeat (3) @(posedge SYS_CLK_I);
    chk("wait_frm", WAIT_FRM_O, 1'b1);
    bus(1'b1, {1'b0, ACQTC_CTRL_OFS}, 32'h3);
    bus(1'b1, {1'b0, ACQTC_MIN_PER_OFS}, 32'h1);
    repeat (150) @(posedge SYS_CLK_I);
    chk("wait_acq", WAIT_ACQ_O, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b1, {1'b0, ACQTC_FRM_COUNT_OFS}, {16'h0, rows[i].cnt});
      bus(1'b1, {1'b0, ACQTC_PERIOD_OFS}, {8'h0, rows[i].per});
      base = nfr;
      bus(1'b1, {1'b0, ACQTC_CTRL_OFS}, {26'h0, rows[i].ctrl});
      repeat (rows[i].edges) ext.edge_once(i[0] ? 2 : 8);
      repeat (rows[i].wt) @(posedge SYS_CLK_I);
      chk("frames", nfr - base, rows[i].frames);
      chk("wait_acq", WAIT_ACQ_O, rows[i].acq);
      chk("line_oe_n", LINE1_OE_N_O, rows[i].oen);
      chk("line_out", LINE1_O, rows[i].ctrl[ACQTC_CTRL_LINE_VAL_BIT]);
      bus(1'b0, ACQTC_STAT_OFS, 32'h0);
      chk("frame_cnt", q[23:8], rows[i].fcnt);
      chk("line_lvl", q[ACQTC_STAT_LINE_BIT], rows[i].ctrl[ACQTC_CTRL_LINE_VAL_BIT]);
    end
    // Reset again in mid-run, while frames are free running
    RST_N_I <= 1'b0;
    repeat (3) @(posedge SYS_CLK_I);
    RST_N_I <= 1'b1;
    bus(1'b0, {1'b0, ACQTC_CTRL_OFS}, 32'h0);
    chk("ctrl", q, 32'h0);
    chk("line_oe_n", LINE1_OE_N_O, 1'b1);
    chk("line_out", LINE1_O, 1'b0);
    bus(1'b0, {1'b0, ACQTC_FRM_COUNT_OFS}, 32'h0);
    chk("frame_count", q, 32'h1);
    bus(1'b0, {1'b0, ACQTC_MIN_PER_OFS}, 32'h0);
    chk("min_period", q, 32'h2710);
    bus(1'b0, ACQTC_STAT_OFS, 32'h0);
    chk("status", q, 32'h2);
    bus(1'b1, 5'h14, 32'hFFFFFFFF);
    bus(1'b0, 5'h14, 32'h0);
    chk("unmapped", q, 32'h0);
    final_report();
  end

  initial
  begin
    repeat (100000) @(posedge SYS_CLK_I);
    err_count++;
    final_report();
  end
endmodule // acqtc_top_test
